// >>> rtl/ipmcf_pkg.sv
// constants and types for the ipv6 multicast class filter
package ipmcf_pkg;

  // byte counter width, enough to reach the udp destination port
  localparam int unsigned CNT_W = 6;
  localparam logic [5:0] CNT_MAX = 6'h3F;

  // byte offsets within the received frame (no vlan tag)
  localparam logic [5:0] OFS_DMAC_END   = 6'h06; // bytes 0..5 hold the destination mac
  localparam logic [5:0] OFS_ETYPE_HI   = 6'h0C;
  localparam logic [5:0] OFS_ETYPE_LO   = 6'h0D;
  localparam logic [5:0] OFS_NXT_HDR    = 6'h14;
  localparam logic [5:0] OFS_ICMP_TYPE  = 6'h36;
  localparam logic [5:0] OFS_UDP_DP_HI  = 6'h38;
  localparam logic [5:0] OFS_UDP_DP_LO  = 6'h39;

  // header values that the classes look for
  localparam logic [47:0] MAC_ALL_NODES = 48'h3333_0000_0001;
  localparam logic [47:0] MAC_DHCP_RS   = 48'h3333_0001_0002;
  localparam logic [47:0] MAC_DHCP_SRV  = 48'h3333_0001_0003;
  localparam logic [15:0] ETYPE_IPV6    = 16'h86DD;
  localparam logic [7:0]  NH_ICMPV6     = 8'h3A;   // 58
  localparam logic [7:0]  NH_UDP        = 8'h11;   // 17
  localparam logic [7:0]  ICMP_RTR_ADV  = 8'h86;   // 134
  localparam logic [15:0] PORT_DHCP_SRV = 16'h0223; // 547
  localparam logic [15:0] PORT_DHCP_CLI = 16'h0222; // 546

  // positions in the filter settings word and in the class vector
  localparam int unsigned SET_RTR_ADV  = 1;
  localparam int unsigned SET_DHCP_RS  = 2;
  localparam int unsigned SET_DHCP_CLI = 3;
  localparam int unsigned CLS_RTR_ADV  = 0;
  localparam int unsigned CLS_DHCP_RS  = 1;
  localparam int unsigned CLS_DHCP_CLI = 2;
  localparam logic [2:0]  CLS_ALL      = 3'h7;

  // header fields captured while a frame streams past
  typedef struct packed {
    logic [47:0] dmac;
    logic [15:0] etype;
    logic [7:0]  nxt_hdr;
    logic [7:0]  icmp_type;
    logic [15:0] udp_dport;
  } ipmcf_cap_t;

  // per-frame decision
  typedef struct packed {
    logic       valid;
    logic       fwd;
    logic       mcast;
    logic [2:0] match;
  } ipmcf_dec_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FRAME = 2'b10
  } ipmcf_state_t;

endpackage

// >>> rtl/ipmcf_filter.sv
// ipv6 multicast class filter: router advertisement and dhcpv6 classes
// Operation
// (RULE1) a class whose enable bit is set has its frames forwarded to the controller.
// (RULE2) a multicast frame of a class whose enable bit is clear is discarded.
// (RULE3) a frame falls in a class only when all of that class's header checks hold together.
// (RULE4) router advertisement needs destination mac 33:33:00:00:00:01.
// (RULE5) router advertisement needs next header 58 and icmpv6 type 134.
// (RULE6) every class here needs ethertype 0x86DD.
// (RULE7) dhcpv6 relay and server class takes destination mac 33:33:00:01:00:02 or :03.
// (RULE8) both dhcpv6 classes need next header 17.
// (RULE9) dhcpv6 relay and server class needs udp destination port 547.
// (RULE10) dhcpv6 server to client class needs destination mac exactly 33:33:00:01:00:02.
// (RULE11) dhcpv6 server to client class needs udp destination port 546.
// (RULE12) with global multicast filtering on, only multicasts hitting an address or class pass.
// (RULE13) the controller should not enable classes the channel does not advertise.
// (RULE14) forward is the or of each class match and its enable, or a mac filter hit.
`timescale 1ns/1ns
module ipmcf_filter
  import ipmcf_pkg::*;
#(
  parameter logic [2:0] CLASS_CAPS = CLS_ALL // classes this channel advertises
)(
  // clock, reset, enable
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // received frame byte stream
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_sof,
  input  wire logic        i_rx_eof,
  input  wire logic [7:0]  i_rx_data,
  // filter configuration and address filter result
  input  wire logic [31:0] i_filt_settings,
  input  wire logic        i_glob_mcast_en,
  input  wire logic        i_mac_hit,
  // per-frame decision
  output logic             o_dec_valid,
  output logic             o_forward,
  output logic             o_mcast,
  output logic [2:0]       o_class_match
);

  // header checks for the three classes
  function automatic logic [2:0] classify(input ipmcf_cap_t c);
    logic ip6;
    logic [2:0] m;
    ip6 = (c.etype == ETYPE_IPV6); // see (RULE6)
    m = '0;
    // all terms and-ed, so a single failed check drops the class, see (RULE3)
    m[CLS_RTR_ADV] = ip6 && (c.dmac == MAC_ALL_NODES) // see (RULE4)
                     && (c.nxt_hdr == NH_ICMPV6) && (c.icmp_type == ICMP_RTR_ADV); // see (RULE5)
    m[CLS_DHCP_RS] = ip6 && ((c.dmac == MAC_DHCP_RS) || (c.dmac == MAC_DHCP_SRV)) // see (RULE7)
                     && (c.nxt_hdr == NH_UDP) // see (RULE8)
                     && (c.udp_dport == PORT_DHCP_SRV); // see (RULE9)
    m[CLS_DHCP_CLI] = ip6 && (c.dmac == MAC_DHCP_RS) // see (RULE10)
                     && (c.nxt_hdr == NH_UDP) // see (RULE8)
                     && (c.udp_dport == PORT_DHCP_CLI); // see (RULE11)
    return m;
  endfunction

  ipmcf_state_t   st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  ipmcf_cap_t     cap_q, cap_d;
  ipmcf_dec_t     dec_q, dec_d;
  logic [2:0]     en_q, en_d;
  logic           hit_q, hit_d;
  logic           glob_q, glob_d;

  // next state of the parser and capture registers
  always_comb
  begin
    logic [CNT_W-1:0] idx;
    logic [2:0]       en;
    logic             take;
    idx   = cnt_q;
    en    = '0;
    take  = 1'b0;
    st_d  = st_q;
    cnt_d = cnt_q;
    cap_d = cap_q;
    dec_d = dec_q;
    en_d  = en_q;
    hit_d = hit_q;
    glob_d = glob_q;
    dec_d.valid = 1'b0;
    if (i_rx_valid)
    begin
      // a start byte always restarts, so a truncated frame cannot leak fields
      if (i_rx_sof)
      begin
        idx   = '0;
        cap_d = '0;
        take  = 1'b1;
      end
      else
      begin
        take = (st_q == ST_FRAME);
      end
    end
    if (take)
    begin
      unique case (idx)
        OFS_ETYPE_HI:  cap_d.etype[15:8]     = i_rx_data;
        OFS_ETYPE_LO:  cap_d.etype[7:0]      = i_rx_data;
        OFS_NXT_HDR:   cap_d.nxt_hdr         = i_rx_data;
        OFS_ICMP_TYPE: cap_d.icmp_type       = i_rx_data;
        OFS_UDP_DP_HI: cap_d.udp_dport[15:8] = i_rx_data;
        OFS_UDP_DP_LO: cap_d.udp_dport[7:0]  = i_rx_data;
        default:
        begin
          if (idx < OFS_DMAC_END)
          begin
            cap_d.dmac = {cap_d.dmac[39:0], i_rx_data};
          end
        end
      endcase
      // saturate so long frames do not wrap onto header offsets
      cnt_d = (idx == CNT_MAX) ? idx : idx + CNT_W'(1);
      st_d  = i_rx_eof ? ST_IDLE : ST_FRAME;
      if (i_rx_eof)
      begin
        // unadvertised enable bits are ignored, see (RULE13)
        en[0] = i_filt_settings[SET_RTR_ADV];
        en[1] = i_filt_settings[SET_DHCP_RS];
        en[2] = i_filt_settings[SET_DHCP_CLI];
        en_d  = en & CLASS_CAPS;
        hit_d = i_mac_hit;
        glob_d = i_glob_mcast_en;
        dec_d.valid = 1'b1;
        dec_d.mcast = cap_d.dmac[40]; // group bit of the first byte
        dec_d.match = classify(cap_d);
        // non-multicast frames and unfiltered multicasts pass untouched
        if (!dec_d.mcast || !glob_d)
        begin
          dec_d.fwd = 1'b1;
        end
        else
        begin
          dec_d.fwd = hit_d || |(dec_d.match & en_d); // see (RULE1) (RULE2) (RULE12) (RULE14)
        end
      end
    end
  end

  // register stage, frozen while the clock enable is low
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_q   <= ST_IDLE;
      cnt_q  <= '0;
      cap_q  <= '0;
      dec_q  <= '0;
      en_q   <= '0;
      hit_q  <= 1'b0;
      glob_q <= 1'b0;
    end
    else if (i_ce)
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      cap_q  <= cap_d;
      dec_q  <= dec_d;
      en_q   <= en_d;
      hit_q  <= hit_d;
      glob_q <= glob_d;
    end
  end

  // decision outputs straight from flip-flops
  assign o_dec_valid   = dec_q.valid;
  assign o_forward     = dec_q.fwd;
  assign o_mcast       = dec_q.mcast;
  assign o_class_match = dec_q.match;

  // checks on the decision
  sequence s_last_byte;
    i_ce && i_rx_valid && i_rx_eof && (i_rx_sof || st_q == ST_FRAME);
  endsequence

  sequence s_filtered_dec;
    o_dec_valid && o_mcast && glob_q;
  endsequence

  property p_dec_follows_eof;
    @(posedge i_mclk) disable iff (!i_rstn)
    s_last_byte |=> o_dec_valid;
  endproperty
  a_dec_follows_eof: assert property (p_dec_follows_eof) // see (RULE14)
    else $error("no decision one cycle after last byte");

  property p_enabled_pass;
    @(posedge i_mclk) disable iff (!i_rstn)
    o_dec_valid && |(o_class_match & en_q) |-> o_forward;
  endproperty
  a_enabled_pass: assert property (p_enabled_pass) // see (RULE1)
    else $error("enabled class frame not forwarded");

  property p_disabled_drop;
    @(posedge i_mclk) disable iff (!i_rstn)
    s_filtered_dec and (!hit_q && (o_class_match & en_q) == 3'h0) |-> !o_forward;
  endproperty
  a_disabled_drop: assert property (p_disabled_drop) // see (RULE2)
    else $error("disabled class multicast forwarded");

  property p_ra_all_checks;
    @(posedge i_mclk) disable iff (!i_rstn)
    o_dec_valid && cap_q.dmac == MAC_ALL_NODES && cap_q.etype == ETYPE_IPV6
      && cap_q.nxt_hdr == NH_ICMPV6 && cap_q.icmp_type == ICMP_RTR_ADV
      |-> o_class_match[CLS_RTR_ADV];
  endproperty
  a_ra_all_checks: assert property (p_ra_all_checks) // see (RULE3)
    else $error("router advertisement not recognised");

  property p_ra_mac;
    @(posedge i_mclk) disable iff (!i_rstn)
    o_dec_valid && o_class_match[CLS_RTR_ADV] |-> cap_q.dmac == MAC_ALL_NODES;
  endproperty
  a_ra_mac: assert property (p_ra_mac) // see (RULE4)
    else $error("router advertisement with wrong mac");

  property p_ra_icmp;
    @(posedge i_mclk) disable iff (!i_rstn)
    o_dec_valid && o_class_match[CLS_RTR_ADV]
      |-> cap_q.nxt_hdr == NH_ICMPV6 && cap_q.icmp_type == ICMP_RTR_ADV;
  endproperty
  a_ra_icmp: assert property (p_ra_icmp) // see (RULE5)
    else $error("router advertisement with wrong icmp fields");

  property p_etype;
    @(posedge i_mclk) disable iff (!i_rstn)
    o_dec_valid && |o_class_match |-> cap_q.etype == ETYPE_IPV6;
  endproperty
  a_etype: assert property (p_etype) // see (RULE6)
    else $error("class match without ipv6 ethertype");

  property p_rs_fields;
    @(posedge i_mclk) disable iff (!i_rstn)
    o_dec_valid && o_class_match[CLS_DHCP_RS]
      |-> (cap_q.dmac == MAC_DHCP_RS || cap_q.dmac == MAC_DHCP_SRV)
          && cap_q.nxt_hdr == NH_UDP && cap_q.udp_dport == PORT_DHCP_SRV;
  endproperty
  a_rs_fields: assert property (p_rs_fields) // see (RULE7) (RULE8) (RULE9)
    else $error("dhcpv6 relay class with wrong fields");

  property p_cli_fields;
    @(posedge i_mclk) disable iff (!i_rstn)
    o_dec_valid && o_class_match[CLS_DHCP_CLI]
      |-> cap_q.dmac == MAC_DHCP_RS && cap_q.nxt_hdr == NH_UDP
          && cap_q.udp_dport == PORT_DHCP_CLI;
  endproperty
  a_cli_fields: assert property (p_cli_fields) // see (RULE10) (RULE11) (RULE8)
    else $error("dhcpv6 client class with wrong fields");

  property p_glob_only_hits;
    @(posedge i_mclk) disable iff (!i_rstn)
    s_filtered_dec and o_forward |-> hit_q || |(o_class_match & en_q);
  endproperty
  a_glob_only_hits: assert property (p_glob_only_hits) // see (RULE12)
    else $error("filtered multicast forwarded without a hit");

  // a match in an unadvertised class alone must not let a filtered multicast through
  property p_caps_mask;
    @(posedge i_mclk) disable iff (!i_rstn)
    s_filtered_dec and (!hit_q && (o_class_match & CLASS_CAPS) == 3'h0) |-> !o_forward;
  endproperty
  a_caps_mask: assert property (p_caps_mask) // see (RULE13)
    else $error("unadvertised class match forwarded");

endmodule

// >>> tb/ipmcf_frame_src.sv
// network side frame source feeding the filter byte stream
`timescale 1ns/1ns
module ipmcf_frame_src
  import ipmcf_pkg::*;
(
  // clock and request
  input  wire logic       i_mclk,
  input  wire logic       i_go,
  input  wire ipmcf_cap_t i_cap,
  input  wire logic [1:0] i_gap,
  // byte stream
  output logic            o_valid,
  output logic            o_sof,
  output logic            o_eof,
  output logic [7:0]      o_data,
  output logic            o_busy
);
  // header byte at offset k, filler elsewhere
  function automatic logic [7:0] byte_at(input int k);
    case (k)
      0, 1, 2, 3, 4, 5: byte_at = i_cap.dmac[47-8*k -: 8];
      12: byte_at = i_cap.etype[15:8];
      13: byte_at = i_cap.etype[7:0];
      20: byte_at = i_cap.nxt_hdr;
      54: byte_at = i_cap.icmp_type;
      56: byte_at = i_cap.udp_dport[15:8];
      57: byte_at = i_cap.udp_dport[7:0];
      default: byte_at = 8'(k) ^ 8'hA5;
    endcase
  endfunction
  initial
  begin
    {o_valid, o_sof, o_eof, o_data, o_busy} = '0;
  end
  // one frame per go; idle data inverts so a stale byte never repeats
  always @(posedge i_mclk)
  begin
    if (i_go && !o_busy)
    begin
      for (int k = 0; k < 58; k++)
      begin
        #1;
        o_busy  = 1'b1;
        o_valid = 1'b1;
        o_sof   = (k == 0);
        o_eof   = (k == 57);
        o_data  = byte_at(k);
        @(posedge i_mclk);
        if (i_gap != 0 && k != 57)
        begin
          #1 o_valid = 1'b0;
          o_data = ~o_data;
          repeat (i_gap) @(posedge i_mclk);
        end
      end
      #1 {o_valid, o_sof, o_eof, o_busy} = '0;
      o_data = ~o_data;
    end
  end
endmodule

// >>> tb/ipmcf_filter_tb_top.sv
// self-checking bench for the ipv6 multicast class filter
`timescale 1ns/1ns
module ipmcf_filter_tb_top
  import ipmcf_pkg::*;
();
  // second filter copy leaves the relay class unadvertised
  localparam logic [2:0] CAPS_PART = 3'h5;
  logic        i_mclk, i_rstn, go, glob, hit, rx_valid, rx_sof, rx_eof, busy, ce;
  logic        dec_valid, fwd, mcast, fwd_c;
  logic [5:0]  last; // expected {class_match, mcast, forward, forward of the second copy}
  logic [1:0]  gap;
  logic [2:0]  cmatch;
  logic [7:0]  rx_data;
  logic [31:0] sett;
  ipmcf_cap_t  cap;
  int          failures, compares, seed;

  ipmcf_frame_src i_src (.i_mclk(i_mclk), .i_go(go), .i_cap(cap), .i_gap(gap),
    .o_valid(rx_valid), .o_sof(rx_sof), .o_eof(rx_eof), .o_data(rx_data), .o_busy(busy));
  ipmcf_filter i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(ce), .i_rx_valid(rx_valid),
    .i_rx_sof(rx_sof), .i_rx_eof(rx_eof), .i_rx_data(rx_data), .i_filt_settings(sett),
    .i_glob_mcast_en(glob), .i_mac_hit(hit), .o_dec_valid(dec_valid), .o_forward(fwd),
    .o_mcast(mcast), .o_class_match(cmatch));
  // a copy with a reduced capability set, so the enable mask is really exercised
  ipmcf_filter #(.CLASS_CAPS(CAPS_PART)) i_dut_caps (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_ce(ce), .i_rx_valid(rx_valid), .i_rx_sof(rx_sof), .i_rx_eof(rx_eof),
    .i_rx_data(rx_data), .i_filt_settings(sett), .i_glob_mcast_en(glob), .i_mac_hit(hit),
    .o_dec_valid(), .o_forward(fwd_c), .o_mcast(), .o_class_match());

  // raw class matches worked out from the header fields
  function automatic logic [2:0] exp_match(input ipmcf_cap_t c);
    logic v6;
    v6 = (c.etype == 16'h86DD);
    exp_match[0] = v6 && c.dmac == 48'h3333_0000_0001 && c.nxt_hdr == 8'd58
                   && c.icmp_type == 8'd134;
    exp_match[1] = v6 && (c.dmac == 48'h3333_0001_0002 || c.dmac == 48'h3333_0001_0003)
                   && c.nxt_hdr == 8'd17 && c.udp_dport == 16'd547;
    exp_match[2] = v6 && c.dmac == 48'h3333_0001_0002 && c.nxt_hdr == 8'd17
                   && c.udp_dport == 16'd546;
  endfunction

  task automatic chk1(input string n, input logic e, input logic s);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic chk3(input string n, input logic [2:0] e, input logic [2:0] s);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s expected %b seen %b", n, e, s);
    end
  endtask

  // one frame of class cls with header field bad spoiled, then the decision
  task automatic run_frame(input int cls, input int bad, input logic [31:0] s,
                           input logic g, input logic h, input logic f);
    int          n;
    logic [2:0]  m;
    @(posedge i_mclk);
    #1 cap = {$random(seed), $random(seed), $random(seed)};
    if (cls == 0)
      cap = {48'h3333_0000_0001, 16'h86DD, 8'd58, 8'd134, cap.udp_dport};
    if (cls == 1)
      cap = {47'h1999_8000_8001, 1'($random(seed)), 16'h86DD, 8'd17, cap.icmp_type, 16'd547};
    if (cls == 2)
      cap = {48'h3333_0001_0002, 16'h86DD, 8'd17, cap.icmp_type, 16'd546};
    // spoiling swaps 58 with 17 and 547 with 546 to probe neighbouring classes
    case (bad)
      1: cap.dmac ^= 48'h1;
      2: cap.etype ^= 16'h1;
      3: cap.nxt_hdr ^= 8'h2B;
      4: cap.icmp_type = 8'd136;
      5: cap.udp_dport ^= 16'h1;
      default: ;
    endcase
    {sett, glob, hit, go, ce} = {s, g, h, 1'b1, !f}; // the first copy's caps advertise every class, the second copy's leave out the relay class
    gap = 2'($unsigned($random(seed)) % 3);
    @(posedge i_mclk);
    #1 go = 1'b0;
    n = 0;
    do
    begin
      @(posedge i_mclk);
      #2 n++;
    end
    while (busy === 1'b1 && n < 400);
    m = exp_match(cap);
    // a frame sent while frozen leaves the previous decision standing
    if (!f)
    begin
      last = {m, cap.dmac[40], !cap.dmac[40] || !g || h || |(m & s[3:1]),
              !cap.dmac[40] || !g || h || |(m & s[3:1] & CAPS_PART)};
    end
    chk1("busy", 1'b0, busy);
    chk1("dec_valid", !f, dec_valid);
    chk3("class_match", last[5:3], cmatch);
    chk1("mcast", last[2], mcast);
    chk1("forward", last[1], fwd);
    chk1("forward_caps", last[0], fwd_c);
    @(posedge i_mclk);
    #2 chk1("dec_valid", 1'b0, dec_valid);
    chk3("class_match", last[5:3], cmatch);
  endtask

  task automatic finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // free running clock
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // hang guard
  initial
  begin
    #700000;
    failures++;
    finish_test;
  end

  // every class against every spoiled field, then random traffic, then a reset
  initial
  begin
    seed = 32'hd8aa_5a34;
    {i_rstn, go, glob, hit, gap, sett, cap} = '0;
    ce = 1'b1;
    repeat (16) @(posedge i_mclk);
    #1 chk1("forward", 1'b0, fwd);
    i_rstn = 1'b1;
    for (int e = 0; e < 2; e++)
      for (int c = 0; c < 4; c++)
        for (int b = 0; b < 6; b++)
          run_frame(c, b, {32{e == 1}} ^ 32'h0000_0004, 1'b1, 1'b0, 1'b0);
    // random traffic, about one frame in eight sent with the clock enable low
    for (int i = 0; i < 200; i++)
      run_frame($unsigned($random(seed)) % 4, $unsigned($random(seed)) % 8,
                $random(seed), 1'($random(seed)), 1'($random(seed)),
                ($random(seed) & 7) == 0);
    // a reset in mid-run clears the decision, and the next frame decides afresh
    @(posedge i_mclk);
    #1 i_rstn = 1'b0;
    #1 chk3("class_match", 3'h0, cmatch);
    chk1("dec_valid", 1'b0, dec_valid);
    chk1("forward", 1'b0, fwd);
    @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    run_frame(1, 0, 32'h0000_0004, 1'b1, 1'b0, 1'b0);
    finish_test;
  end
endmodule
